// [logic/udpm_pkg.sv]
package udpm_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] IER_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int MCR_OP1_BIT = 2;
  localparam int MCR_OP2_BIT = 3;
  localparam int MCR_WOR_BIT = 5;
  localparam int ROUTE_LSB = 8;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [1:0] ROUTE_RST = 2'h0;
  localparam logic [3:0] IER_RST = 4'h0;

  // ----------------------------------------------------------------
  // interrupt condition bits and irq routing
  // ----------------------------------------------------------------
  localparam int COND_RX_ERR = 0;
  localparam int COND_RX_DATA = 1;
  localparam int COND_TX_EMPTY = 2;
  localparam int COND_MODEM = 3;
  localparam logic [1:0] ROUTE_A = 2'h0;
  localparam logic [1:0] ROUTE_B = 2'h1;
  localparam logic [1:0] ROUTE_C = 2'h2;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int ST_MODE_BIT = 4;
  localparam int ST_IRQ_BIT = 5;
  localparam int ST_RECEIVE_READY_N_BIT = 6;
  localparam int ST_TRANSMIT_READY_N_BIT = 7;
  localparam int ST_COM_BIT = 8;
endpackage

// [logic/udpm_if.sv]
`timescale 1ns/1ps
// carrier between the top and its two helpers
interface udpm_if;
  logic isa_host_mode;
  logic [7:0] modem_control_reg;
  logic [3:0] interrupt_enable_reg;
  logic [3:0] cond;
  logic irq_req;
  logic [9:3] addr;
  logic aen_n;
  logic [2:0] sel;
  logic com_hit;
  logic lpt1_hit;
  logic lpt2_hit;

  modport top (output isa_host_mode, modem_control_reg, interrupt_enable_reg, cond, addr,
    aen_n, sel, input irq_req, com_hit, lpt1_hit, lpt2_hit);
  modport irq (input isa_host_mode, modem_control_reg, interrupt_enable_reg, cond,
    output irq_req);
  modport dec (input isa_host_mode, addr, aen_n, sel, output com_hit, lpt1_hit, lpt2_hit);
endinterface

// [logic/udpm_irq.sv]
`timescale 1ns/1ps
module udpm_irq (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // carrier
  udpm_if.irq bus
);
  logic irq_req;
  logic next_irq_req;

  // ----------------------------------------------------------------
  // qualified interrupt request
  // ----------------------------------------------------------------
  // any enabled condition; host mode also needs the control gate bit
  always_comb begin
    next_irq_req = |(bus.interrupt_enable_reg & bus.cond);
    if (bus.isa_host_mode) begin
      next_irq_req = next_irq_req & bus.modem_control_reg[udpm_pkg::MCR_OP2_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else if (ce) begin
      irq_req <= next_irq_req;
    end
  end

  assign bus.irq_req = irq_req;
endmodule // udpm_irq

// [logic/udpm_decode.sv]
`timescale 1ns/1ps
module udpm_decode #(
  parameter logic [9:3] COM0_BASE = 7'h7f,
  parameter logic [9:3] COM1_BASE = 7'h5f,
  parameter logic [9:3] COM2_BASE = 7'h7d,
  parameter logic [9:3] COM3_BASE = 7'h5d,
  parameter logic [9:3] LPT1_BASE = 7'h6f,
  parameter logic [9:3] LPT2_BASE = 7'h4f
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // carrier
  udpm_if.dec bus
);
  logic com_hit;
  logic lpt1_hit;
  logic lpt2_hit;
  logic next_com_hit;
  logic next_lpt1_hit;
  logic next_lpt2_hit;
  logic [9:3] com_base;

  // ----------------------------------------------------------------
  // address compare
  // ----------------------------------------------------------------
  // selects pick the com base; decoding is only live in host mode
  always_comb begin
    case (bus.sel[1:0])
      2'h0: com_base = COM0_BASE;
      2'h1: com_base = COM1_BASE;
      2'h2: com_base = COM2_BASE;
      default: com_base = COM3_BASE;
    endcase
    next_com_hit = bus.isa_host_mode & ~bus.aen_n & bus.sel[2]
      & (bus.addr == com_base);
    next_lpt1_hit = bus.isa_host_mode & ~bus.aen_n & (bus.addr == LPT1_BASE);
    next_lpt2_hit = bus.isa_host_mode & ~bus.aen_n & (bus.addr == LPT2_BASE);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      com_hit <= 1'b0;
      lpt1_hit <= 1'b0;
      lpt2_hit <= 1'b0;
    end else if (ce) begin
      com_hit <= next_com_hit;
      lpt1_hit <= next_lpt1_hit;
      lpt2_hit <= next_lpt2_hit;
    end
  end

  assign bus.com_hit = com_hit;
  assign bus.lpt1_hit = lpt1_hit;
  assign bus.lpt2_hit = lpt2_hit;
endmodule // udpm_decode

// [logic/udpm_top.sv]
// Function
// - host mode: line A high only with control bit 3, enables, pending condition.
// - conditions: receive error, receive data, transmit empty, modem status change.
// - general mode: first interrupt pin driven unless control bit 5 is set, single active-high request.
// - control bit 5 makes interrupt pin open-source for wired-or sharing.
// - host mode: line B carries the request, qualified like line A.
// - general mode: receive-ready low while holding register full or fifo non-empty.
// - host mode: line C carries the request, qualified like line A.
// - general mode: transmit-ready low while any transmit location free.
// - host mode: baud clock feeds receiver internally; baud pin is printer decode one.
// - general mode: baud pin outputs the 16x baud generator clock.
// - host mode: drive-disable pin is printer decode two, active low.
// - general mode: drive-disable low during cpu read, high otherwise.
// - user output one is inverse of control bit 2.
// - reset returns every register and output to its reset state.
// - transmitter output and receiver input disabled while reset is high.
// - host mode: selects plus address 3..9 pick com port; select one ignored otherwise.
// - general mode: receiver clock taken from select-two pin.
// - general mode: select-three pin drives user output two from control bit 3.
// - mode-select low gives host mode, high gives general mode.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module udpm_top (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode strap and isa address
  input wire logic mode_select,
  input wire logic [9:3] isa_addr,
  input wire logic aen_n,
  input wire logic cpu_read,
  // uart core status
  input wire logic rx_error,
  input wire logic rx_data_avail,
  input wire logic tx_empty,
  input wire logic modem_change,
  input wire logic rhr_full,
  input wire logic rx_fifo_nonempty,
  input wire logic tx_space_free,
  input wire logic baud16x_clk,
  // uart core control
  output logic rx_clk,
  output logic tx_enable,
  output logic rx_enable,
  output logic com_select,
  // interrupt pins with enables
  output logic irq_line_a,
  output logic irq_line_a_oe,
  output logic irq_line_b,
  output logic irq_line_b_oe,
  output logic irq_line_c,
  output logic irq_line_c_oe,
  // dual-function pins
  output logic baud_clock_out_n,
  output logic bus_drive_disable_n,
  output logic user_output_one_n,
  input wire logic port_select_one,
  input wire logic port_select_two,
  input wire logic port_select_three_in,
  output logic port_select_three_out,
  output logic port_select_three_oe
);
  udpm_if cbus ();

  logic isa_host_mode;
  logic [7:0] modem_control_reg;
  logic [1:0] irq_route;
  logic [3:0] interrupt_enable_reg;
  logic [31:0] rdata;
  logic next_isa_host_mode;
  logic [7:0] next_modem_control_reg;
  logic [1:0] next_irq_route;
  logic [3:0] next_interrupt_enable_reg;
  logic [31:0] next_rdata;
  logic setup;
  logic access;
  logic mapped;
  logic [3:0] cond;
  logic rx_ready;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  udpm_irq u_irq (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .bus(cbus.irq)
  );

  udpm_decode u_decode (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .bus(cbus.dec)
  );

  // conditions feeding the qualifier
  always_comb begin
    cond = 4'h0;
    cond[udpm_pkg::COND_RX_ERR] = rx_error;
    cond[udpm_pkg::COND_RX_DATA] = rx_data_avail;
    cond[udpm_pkg::COND_TX_EMPTY] = tx_empty;
    cond[udpm_pkg::COND_MODEM] = modem_change;
    rx_ready = rhr_full | rx_fifo_nonempty;
  end

  assign cbus.isa_host_mode = isa_host_mode;
  assign cbus.modem_control_reg = modem_control_reg;
  assign cbus.interrupt_enable_reg = interrupt_enable_reg;
  assign cbus.cond = cond;
  assign cbus.addr = isa_addr;
  assign cbus.aen_n = aen_n;
  // select one only matters in host mode; decode is gated by mode anyway
  assign cbus.sel = {port_select_three_in, port_select_two,
    port_select_one & isa_host_mode};

  // ----------------------------------------------------------------
  // apb slave and registers
  // ----------------------------------------------------------------
  // read data is captured in setup, so the access phase needs no wait
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable;
    mapped = (paddr == udpm_pkg::CTRL_OFS) | (paddr == udpm_pkg::IER_OFS)
      | (paddr == udpm_pkg::STATUS_OFS);
    pready = access & ce;
    pslverr = access & ce & ~mapped;
    next_isa_host_mode = isa_host_mode;
    next_modem_control_reg = modem_control_reg;
    next_irq_route = irq_route;
    next_interrupt_enable_reg = interrupt_enable_reg;
    next_rdata = rdata;
    if (setup) begin
      next_rdata = 32'h0;
      case (paddr)
        udpm_pkg::CTRL_OFS: begin
          next_rdata[7:0] = modem_control_reg;
          next_rdata[udpm_pkg::ROUTE_LSB +: 2] = irq_route;
        end
        udpm_pkg::IER_OFS: begin
          next_rdata[3:0] = interrupt_enable_reg;
        end
        udpm_pkg::STATUS_OFS: begin
          next_rdata[3:0] = cond & interrupt_enable_reg;
          next_rdata[udpm_pkg::ST_MODE_BIT] = isa_host_mode;
          next_rdata[udpm_pkg::ST_IRQ_BIT] = cbus.irq_req;
          next_rdata[udpm_pkg::ST_RECEIVE_READY_N_BIT] = rx_ready;
          next_rdata[udpm_pkg::ST_TRANSMIT_READY_N_BIT] = tx_space_free;
          next_rdata[udpm_pkg::ST_COM_BIT] = cbus.com_hit;
        end
        default: begin
          next_rdata = 32'h0;
        end
      endcase
    end
    if (access & pwrite) begin
      case (paddr)
        udpm_pkg::CTRL_OFS: begin
          next_modem_control_reg = pwdata[7:0];
          next_irq_route = pwdata[udpm_pkg::ROUTE_LSB +: 2];
        end
        udpm_pkg::IER_OFS: begin
          next_interrupt_enable_reg = pwdata[3:0];
        end
        default: begin
          next_interrupt_enable_reg = interrupt_enable_reg;
        end
      endcase
    end
    // strap is caught while reset is held, never afterwards
    if (rst) begin
      next_isa_host_mode = ~mode_select;
    end
  end

  // register state; reset clears everything, mode strap is clocked in
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modem_control_reg <= udpm_pkg::MCR_RST;
      irq_route <= udpm_pkg::ROUTE_RST;
      interrupt_enable_reg <= udpm_pkg::IER_RST;
      rdata <= 32'h0;
      isa_host_mode <= next_isa_host_mode;
    end else if (ce) begin
      modem_control_reg <= next_modem_control_reg;
      irq_route <= next_irq_route;
      interrupt_enable_reg <= next_interrupt_enable_reg;
      rdata <= next_rdata;
      isa_host_mode <= next_isa_host_mode;
    end
  end

  assign prdata = rdata;

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  logic p_irq_a, p_irq_a_oe, p_irq_b, p_irq_b_oe, p_irq_c, p_irq_c_oe;
  logic p_baud_n, p_bus_drive_disable_n_n, p_op1_n, p_s3_out, p_s3_oe, p_rx_clk, p_com, p_en;
  logic next_irq_a, next_irq_a_oe, next_irq_b, next_irq_b_oe, next_irq_c, next_irq_c_oe;
  logic next_baud_n, next_bus_drive_disable_n_n, next_op1_n, next_s3_out, next_s3_oe, next_rx_clk;
  logic next_com;
  logic irq;
  logic wired_or;

  always_comb begin
    irq = cbus.irq_req;
    wired_or = modem_control_reg[udpm_pkg::MCR_WOR_BIT];
    next_op1_n = ~modem_control_reg[udpm_pkg::MCR_OP1_BIT];
    next_com = cbus.com_hit;
    if (isa_host_mode) begin
      // host mode: request appears only on the routed line, others float
      next_irq_a = (irq_route == udpm_pkg::ROUTE_A) & irq;
      next_irq_b = (irq_route == udpm_pkg::ROUTE_B) & irq;
      next_irq_c = (irq_route == udpm_pkg::ROUTE_C) & irq;
      next_irq_a_oe = modem_control_reg[udpm_pkg::MCR_OP2_BIT] & (irq_route == udpm_pkg::ROUTE_A);
      next_irq_b_oe = modem_control_reg[udpm_pkg::MCR_OP2_BIT] & (irq_route == udpm_pkg::ROUTE_B);
      next_irq_c_oe = modem_control_reg[udpm_pkg::MCR_OP2_BIT] & (irq_route == udpm_pkg::ROUTE_C);
      next_baud_n = ~cbus.lpt1_hit;
      next_rx_clk = baud16x_clk;
      next_bus_drive_disable_n_n = ~cbus.lpt2_hit;
      next_s3_out = 1'b0;
      next_s3_oe = 1'b0;
    end else begin
      next_irq_a = irq;
      next_irq_a_oe = 1'b1;
      next_irq_b = ~rx_ready;
      next_irq_b_oe = 1'b1;
      next_irq_c = ~tx_space_free;
      next_irq_c_oe = 1'b1;
      next_baud_n = baud16x_clk;
      next_rx_clk = port_select_two;
      next_bus_drive_disable_n_n = ~cpu_read;
      next_s3_out = ~modem_control_reg[udpm_pkg::MCR_OP2_BIT];
      next_s3_oe = 1'b1;
    end
    // open-source: only the high level is driven, a resistor pulls low
    if (wired_or) begin
      next_irq_a_oe = next_irq_a_oe & next_irq_a;
    end
  end

  // pin flops; reset parks every pin inactive and stops the serial path
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p_irq_a <= 1'b0;
      p_irq_a_oe <= 1'b0;
      p_irq_b <= 1'b0;
      p_irq_b_oe <= 1'b0;
      p_irq_c <= 1'b0;
      p_irq_c_oe <= 1'b0;
      p_baud_n <= 1'b1;
      p_bus_drive_disable_n_n <= 1'b1;
      p_op1_n <= 1'b1;
      p_s3_out <= 1'b1;
      p_s3_oe <= 1'b0;
      p_rx_clk <= 1'b0;
      p_com <= 1'b0;
      p_en <= 1'b0;
    end else if (ce) begin
      p_irq_a <= next_irq_a;
      p_irq_a_oe <= next_irq_a_oe;
      p_irq_b <= next_irq_b;
      p_irq_b_oe <= next_irq_b_oe;
      p_irq_c <= next_irq_c;
      p_irq_c_oe <= next_irq_c_oe;
      p_baud_n <= next_baud_n;
      p_bus_drive_disable_n_n <= next_bus_drive_disable_n_n;
      p_op1_n <= next_op1_n;
      p_s3_out <= next_s3_out;
      p_s3_oe <= next_s3_oe;
      p_rx_clk <= next_rx_clk;
      p_com <= next_com;
      p_en <= 1'b1;
    end
  end

  assign irq_line_a = p_irq_a;
  assign irq_line_a_oe = p_irq_a_oe;
  assign irq_line_b = p_irq_b;
  assign irq_line_b_oe = p_irq_b_oe;
  assign irq_line_c = p_irq_c;
  assign irq_line_c_oe = p_irq_c_oe;
  assign baud_clock_out_n = p_baud_n;
  assign bus_drive_disable_n = p_bus_drive_disable_n_n;
  assign user_output_one_n = p_op1_n;
  assign port_select_three_out = p_s3_out;
  assign port_select_three_oe = p_s3_oe;
  assign rx_clk = p_rx_clk;
  assign com_select = p_com;
  assign tx_enable = p_en;
  assign rx_enable = p_en;
endmodule // udpm_top

// [sim/udpm_properties.sv]
`timescale 1ns/1ps
// ------
// pin checker, sees the top ports only
// ------
module udpm_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // strap and status inputs
  input wire logic mode_select,
  input wire logic cpu_read,
  input wire logic rx_error,
  input wire logic rx_data_avail,
  input wire logic tx_empty,
  input wire logic modem_change,
  input wire logic rhr_full,
  input wire logic rx_fifo_nonempty,
  input wire logic tx_space_free,
  // outputs watched
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic irq_line_a,
  input wire logic irq_line_a_oe,
  input wire logic irq_line_b,
  input wire logic irq_line_b_oe,
  input wire logic irq_line_c,
  input wire logic irq_line_c_oe,
  input wire logic bus_drive_disable_n
);
  logic host;
  logic [1:0] run;
  wire rx_rdy = rhr_full | rx_fifo_nonempty;
  wire cond_any = rx_error | rx_data_avail | tx_empty | modem_change;
  wire mapped = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
  // mode copy and settle counter; pin checks wait out the two-flop latency
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host <= !mode_select;
      run <= 2'h0;
    end else if (run != 2'h3) begin
      run <= run + 2'h1;
    end
  end
  a_pready_now: assert property (@(posedge sys_clk) disable iff (rst)
    psel && penable |-> pready) else $error("access cycle without ready");
  a_slverr_map: assert property (@(posedge sys_clk) disable iff (rst)
    psel && penable |-> pslverr == !mapped) else $error("error response wrong");
  a_reset_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> !tx_enable && !rx_enable && !irq_line_a_oe && !irq_line_b_oe
    && !irq_line_c_oe && bus_drive_disable_n) else $error("outputs not reset");
  a_enable_release: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |=> tx_enable && rx_enable) else $error("serial enables late");
  a_rxready_pin: assert property (@(posedge sys_clk) disable iff (rst)
    !host && run == 2'h3 && $past(rx_rdy, 1) == rx_rdy && $past(rx_rdy, 2) == rx_rdy
    |-> irq_line_b_oe && irq_line_b == !rx_rdy) else $error("receive ready pin wrong");
  a_txready_pin: assert property (@(posedge sys_clk) disable iff (rst)
    !host && run == 2'h3 && $past(tx_space_free, 1) == tx_space_free
    && $past(tx_space_free, 2) == tx_space_free
    |-> irq_line_c_oe && irq_line_c == !tx_space_free) else $error("transmit ready pin wrong");
  a_drive_disable: assert property (@(posedge sys_clk) disable iff (rst)
    !host && run == 2'h3 && $past(cpu_read, 1) == cpu_read && $past(cpu_read, 2) == cpu_read
    |-> bus_drive_disable_n == !cpu_read) else $error("drive disable wrong");
  a_host_one_line: assert property (@(posedge sys_clk) disable iff (rst)
    host |-> $onehot0({irq_line_a_oe, irq_line_b_oe, irq_line_c_oe}))
    else $error("several request lines driven");
  a_host_irq_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    host && run == 2'h3 && !cond_any && !$past(cond_any, 1) && !$past(cond_any, 2)
    |-> !irq_line_a && !irq_line_b && !irq_line_c) else $error("request without cause");
endmodule // udpm_properties

bind udpm_top udpm_properties udpm_properties_i (.sys_clk, .rst, .psel, .penable, .paddr,
  .pready, .pslverr, .mode_select, .cpu_read, .rx_error, .rx_data_avail, .tx_empty,
  .modem_change, .rhr_full, .rx_fifo_nonempty, .tx_space_free, .tx_enable, .rx_enable,
  .irq_line_a, .irq_line_a_oe, .irq_line_b, .irq_line_b_oe, .irq_line_c, .irq_line_c_oe,
  .bus_drive_disable_n);

// [sim/udpm_far_end.sv]
`timescale 1ns/1ps
// ------
// board side: pull resistors and receive clock strap
// ------
module udpm_far_end (
  // device pins
  input wire logic irq_line_a,
  input wire logic irq_line_a_oe,
  input wire logic s3_out,
  input wire logic s3_oe,
  input wire logic baud_clock_out_n,
  // board straps
  input wire logic tie_rclk,
  input wire logic rclk_src,
  // resolved wires
  output logic irq_wire,
  output logic s3_wire,
  output logic rclk_pin
);
  // shared request line has a resistor to ground
  assign irq_wire = irq_line_a_oe ? irq_line_a : 1'b0;
  // select-three pin has a pull-up when released
  assign s3_wire = s3_oe ? s3_out : 1'b1;
  // equal rates: receive clock wired back from the baud pin
  assign rclk_pin = tie_rclk ? baud_clock_out_n : rclk_src;
endmodule // udpm_far_end

// [sim/udpm_bench.sv]
`timescale 1ns/1ps
module udpm_bench;
  logic sys_clk, rst, ce, psel, penable, pwrite, mode_select, aen_n, cpu_read;
  logic baud16x_clk, port_select_one, tie_rclk, rclk_src, s2, s3, iw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:3] isa_addr;
  logic [3:0] cond;
  logic [2:0] sts;
  logic pready, pslverr, rx_clk, tx_enable, rx_enable, com_select, e;
  logic a, a_oe, b, b_oe, c, c_oe, baud_n, bus_drive_disable_n_n, op1_n, s3_out, s3_oe;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  localparam logic [6:0] COM_BASE [4] = '{7'h7f, 7'h5f, 7'h7d, 7'h5d};
  udpm_top udpm_top_i (.sys_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mode_select, .isa_addr, .aen_n, .cpu_read, .rx_error(cond[0]),
    .rx_data_avail(cond[1]), .tx_empty(cond[2]), .modem_change(cond[3]), .rhr_full(sts[0]),
    .rx_fifo_nonempty(sts[1]), .tx_space_free(sts[2]), .baud16x_clk, .rx_clk, .tx_enable,
    .rx_enable, .com_select, .irq_line_a(a), .irq_line_a_oe(a_oe), .irq_line_b(b),
    .irq_line_b_oe(b_oe), .irq_line_c(c), .irq_line_c_oe(c_oe), .baud_clock_out_n(baud_n),
    .bus_drive_disable_n(bus_drive_disable_n_n), .user_output_one_n(op1_n), .port_select_one,
    .port_select_two(s2), .port_select_three_in(s3), .port_select_three_out(s3_out),
    .port_select_three_oe(s3_oe));
  udpm_far_end udpm_far_end_i (.irq_line_a(a), .irq_line_a_oe(a_oe), .s3_out, .s3_oe,
    .baud_clock_out_n(baud_n), .tie_rclk, .rclk_src, .irq_wire(iw), .s3_wire(s3), .rclk_pin(s2));
  // ------
  // clock, watchdog
  // ------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // ------
  // shared tasks
  // ------
  task summarize;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // setup then access; request held until ready is sampled high
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // no wait limit here: only the watchdog may end a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
    chk("pslverr", 0, e);
  endtask
  // covers the two-edge pin latency
  task settle;
    repeat (4) @(posedge sys_clk);
  endtask
  task do_reset(input logic m);
    rst <= 1'b1;
    mode_select <= m;
    repeat (3) @(posedge sys_clk);
    chk("serial enables", 0, {tx_enable, rx_enable});
    chk("reset pins", 5'h0e, {a_oe, baud_n, bus_drive_disable_n_n, op1_n, s3_oe});
    rst <= 1'b0;
    settle();
  endtask
  // ------
  // scenarios
  // ------
  task t_regs;
    apb(1'b0, udpm_pkg::CTRL_OFS, 0);
    chk("control", 0, q);
    apb(1'b0, udpm_pkg::IER_OFS, 0);
    chk("ier", 0, q);
    wr(udpm_pkg::CTRL_OFS, 32'h0000_02ac);
    apb(1'b0, udpm_pkg::CTRL_OFS, 0);
    chk("control", 32'h0000_02ac, q);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    chk("pslverr", 1, e);
    apb(1'b0, 12'h00c, 0);
    chk("read pslverr", 1, e);
    chk("unmapped", 0, q);
    apb(1'b0, udpm_pkg::STATUS_OFS, 0);
    chk("host flag", 0, q[udpm_pkg::ST_MODE_BIT]);
  endtask
  task t_general;
    // tx space follows bit 0 so that both levels of the ready pin are seen
    for (int i = 0; i < 4; i++) begin
      wr(udpm_pkg::CTRL_OFS, i << 2);
      sts <= {i[0], i[1:0]};
      cpu_read <= i[0];
      settle();
      chk("user out two", {~i[1], ~i[1], 1'b1}, {s3, s3_out, s3_oe});
      chk("user out one", !i[0], op1_n);
      chk("rx ready", i[1:0] == 0, b);
      chk("tx ready", !i[0], c);
      chk("drive disable", !i[0], bus_drive_disable_n_n);
    end
    wr(udpm_pkg::IER_OFS, 32'h0000_000f);
    for (int i = 0; i < 5; i++) begin
      cond <= 4'h1 << i;
      settle();
      chk("int", {1'b1, i < 4}, {a_oe, a});
    end
    wr(udpm_pkg::CTRL_OFS, 32'h0000_0020);
    settle();
    chk("wired-or idle", 0, {a_oe, iw});
    cond <= 4'h8;
    settle();
    chk("wired-or active", 3, {a_oe, iw});
    wr(udpm_pkg::IER_OFS, 0);
    settle();
    chk("masked", 0, iw);
    for (int i = 0; i < 2; i++) begin
      baud16x_clk <= i[0];
      rclk_src <= i[0];
      port_select_one <= i[0];
      settle();
      chk("rx clock", i[0], rx_clk);
      chk("select one", 0, com_select);
      q[i] = baud_n;
    end
    chk("baud toggles", !q[0], q[1]);
    // strap high: receive clock now follows the baud pin, not the free source
    tie_rclk <= 1'b1;
    baud16x_clk <= 1'b0;
    settle();
    chk("rx clock tied", 0, rx_clk);
  endtask
  task t_host;
    apb(1'b0, udpm_pkg::STATUS_OFS, 0);
    chk("host flag", 1, q[udpm_pkg::ST_MODE_BIT]);
    chk("select three", 2'h1, {s3_oe, s3});
    tie_rclk <= 1'b0;
    wr(udpm_pkg::IER_OFS, 32'h0000_0001);
    cond <= 4'h1;
    for (int r = 0; r < 3; r++) begin
      wr(udpm_pkg::CTRL_OFS, (r << 8) | 32'h8);
      settle();
      chk("irq oe", 3'h1 << r, {c_oe, b_oe, a_oe});
      chk("irq value", 3'h1 << r, {c, b, a});
      wr(udpm_pkg::CTRL_OFS, r << 8);
      settle();
      chk("irq gated", 0, {c_oe, b_oe, a_oe});
    end
    for (int i = 0; i < 2; i++) begin
      baud16x_clk <= i[0];
      settle();
      chk("rx clock", i[0], rx_clk);
    end
    aen_n <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      port_select_one <= k[0];
      rclk_src <= k[1];
      isa_addr <= COM_BASE[k];
      settle();
      chk("com hit", 1, com_select);
      isa_addr <= COM_BASE[k] ^ 7'h20;
      settle();
      chk("com miss", 0, com_select);
    end
    isa_addr <= 7'h6f;
    settle();
    chk("printer one", 2'h1, {baud_n, bus_drive_disable_n_n});
    isa_addr <= 7'h4f;
    settle();
    chk("printer two", 2'h2, {baud_n, bus_drive_disable_n_n});
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    {rst, ce, psel, penable, pwrite, aen_n, cpu_read, baud16x_clk} = 8'hc4;
    {mode_select, port_select_one, tie_rclk, rclk_src} = 4'hd;
    paddr = 12'h000;
    pwdata = 32'h0;
    isa_addr = 7'h00;
    cond = 4'h0;
    sts = 3'h0;
    do_reset(1'b1);
    t_regs();
    t_general();
    cond <= 4'h0;
    do_reset(1'b0);
    t_host();
    summarize();
  end
endmodule // udpm_bench
